// File: rtl/osd_pkg.sv
package osd_pkg;
   // ****************************************
   // core data-space addressing
   // ****************************************
   localparam logic [7:0] OSD_PAGE_REG_ADDR = 8'h00_E8;
   localparam logic [7:0] OSD_BANK_ADDR = 8'h00_ED;
   localparam logic [7:0] OSD_WIN_LAST = 8'h00_3F;
   localparam int OSD_PAGE5_BIT = 5;
   localparam int OSD_PAGE6_BIT = 6;
   localparam logic [5:0] OSD_VORG_OFS = 6'h10;
   localparam logic [5:0] OSD_HORG_OFS = 6'h11;
   localparam logic [5:0] OSD_LGAP_OFS = 6'h12;
   localparam logic [5:0] OSD_WGAP_OFS = 6'h13;
   localparam logic [5:0] OSD_BKDP_OFS = 6'h14;
   localparam logic [5:0] OSD_MSW_OFS = 6'h17;
   localparam logic [5:0] OSD_P6_RAM_LAST = 6'h0F;
   localparam int OSD_RAM_WORDS = 80;
   localparam logic [6:0] OSD_P6_RAM_BASE = 7'h40;
   localparam logic [7:0] OSD_REG_RESET = 8'h00;
   // ****************************************
   // field positions
   // ****************************************
   localparam int OSD_WORD_KIND_BIT = 6;    // 1 = space/format word
   localparam int OSD_OUTLINE_BIT = 6;      // in vertical_origin
   localparam int OSD_NOSPACE_BD_BIT = 6;   // in horizontal_origin
   localparam int OSD_BLANK_BIT = 6;        // in line_gap_and_blank
   localparam int OSD_GS_LSB = 6;           // in word_gap_and_size
   // format/space word fields
   localparam int OSD_FW_SIZE = 0;
   localparam int OSD_FW_WGAP = 0;
   localparam int OSD_FW_LGAP = 1;
   localparam int OSD_FW_VIS = 2;
   localparam int OSD_FW_BGS = 3;
   localparam int OSD_FW_RGB_LSB = 4;
   // ****************************************
   // timing
   // ****************************************
   localparam int OSD_H_PER_STEP = 4;       // scan lines per origin/gap step
   localparam int OSD_HSTART_BASE = 10;     // dot periods before first char
   localparam int OSD_OSC_PER_DOT = 2;      // oscillator periods per dot period
   localparam int OSD_SPACE_DOTS = 6;
   localparam int OSD_BOX_W = 7;
   localparam int OSD_BOX_H = 9;

   typedef struct packed {
      logic [5:0] glyph_index;
      logic glyph_bank_bit;
      logic is_glyph;
   } osd_glyph_t;

   typedef struct packed {
      logic [2:0] colour;
      logic draw_backdrop;
      logic [2:0] backdrop_colour;
      logic word_visible;
      logic outline;
   } osd_word_t;
endpackage

// File: rtl/osd_word_decode.sv
`timescale 1ns/100ps
// classifies one display-RAM word and resolves its backdrop
module osd_word_decode (
   input wire logic [6:0] word,
   input wire logic [6:0] fmt_word,
   input wire logic osd_master_on,
   input wire logic glyph_bank_bit,
   input wire logic no_backdrop_on_spaces,
   input wire logic outline_background_bit,
   input wire logic [1:0] backdrop_enables,
   input wire logic [5:0] backdrop_colours,
   output osd_pkg::osd_glyph_t glyph,
   output osd_pkg::osd_word_t attr
);
   import osd_pkg::*;
   logic space;
   logic sel;
   // ****************************************
   // word kind and attribute resolve
   // ****************************************
   always_comb begin
      space = word[OSD_WORD_KIND_BIT];
      sel = fmt_word[OSD_FW_BGS];
      glyph.is_glyph = ~space;
      glyph.glyph_index = word[5:0];
      glyph.glyph_bank_bit = glyph_bank_bit;
      attr.colour = fmt_word[OSD_FW_RGB_LSB +: 3];
      attr.backdrop_colour = sel ? backdrop_colours[5:3] : backdrop_colours[2:0];
      // spaces may drop the backdrop so adjacent colours break cleanly
      attr.draw_backdrop = backdrop_enables[sel] & ~(space & no_backdrop_on_spaces);
      attr.word_visible = osd_master_on & fmt_word[OSD_FW_VIS];
      attr.outline = outline_background_bit;
   end
endmodule

// File: rtl/osd_geometry.sv
`timescale 1ns/100ps
// converts register codes to scan-line and oscillator-period counts
module osd_geometry (
   input wire logic [5:0] top_offset,
   input wire logic [5:0] left_offset,
   input wire logic [5:0] line_gap_value,
   input wire logic line_gap_on,
   input wire logic [5:0] word_gap_value,
   input wire logic word_gap_on,
   input wire logic [1:0] global_height_code,
   input wire logic per_line_height_flag,
   output logic [8:0] top_lines,
   output logic [7:0] left_osc,
   output logic [7:0] line_gap_lines,
   output logic [6:0] char_lines,
   output logic [5:0] char_dots,
   output logic [9:0] word_gap_osc,
   output logic [2:0] scale
);
   import osd_pkg::*;
   logic [7:0] wg;
   // ****************************************
   // size table and spacing formulas
   // ****************************************
   always_comb begin
      unique case ({global_height_code, per_line_height_flag})
         3'b000, 3'b010: scale = 3'd1;
         3'b001, 3'b100, 3'b110: scale = 3'd2;
         3'b011, 3'b101: scale = 3'd3;
         default: scale = 3'd4;
      endcase
      char_lines = 7'(scale * 18);
      char_dots = 6'(scale * OSD_SPACE_DOTS);
      top_lines = 9'(top_offset * OSD_H_PER_STEP);
      left_offset_calc: left_osc = 8'((OSD_HSTART_BASE + left_offset) * OSD_OSC_PER_DOT);
      line_gap_lines = line_gap_on ? 8'(line_gap_value * OSD_H_PER_STEP) : 8'd0;
      wg = 8'(OSD_OSC_PER_DOT * (1 + word_gap_value));
      // largest gap times four reaches 512, hence ten bits
      word_gap_osc = word_gap_on ? 10'(wg * scale) : 10'd0;
   end
endmodule

// File: rtl/osd_ctrl.sv
`timescale 1ns/100ps
module osd_ctrl (
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [7:0] core_addr,
   input wire logic [7:0] core_wdata,
   input wire logic core_wr,
   input wire logic core_rd,
   output logic [7:0] core_rdata,
   input wire logic vsync_in,
   input wire logic [6:0] disp_addr,
   input wire logic [6:0] disp_fmt_addr,
   input wire logic char_active,
   output logic [6:0] disp_word,
   output osd_pkg::osd_glyph_t disp_glyph,
   output osd_pkg::osd_word_t disp_attr,
   output logic osc_run,
   output logic blank_output,
   output logic [8:0] top_lines,
   output logic [7:0] left_osc,
   output logic [7:0] line_gap_lines,
   output logic [6:0] char_lines,
   output logic [5:0] char_dots,
   output logic [9:0] word_gap_osc,
   output logic [2:0] size_scale
);
   import osd_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef enum logic [1:0] {
      OSD_OFF = 2'b01,
      OSD_RUN = 2'b10
   } osd_osc_t;

   typedef struct packed {
      logic [7:0] page;
      logic [7:0] vertical_origin;
      logic [7:0] horizontal_origin;
      logic [7:0] line_gap_and_blank;
      logic [7:0] word_gap_and_size;
      logic [7:0] backdrop_setup;
      logic osd_master_on;
      logic glyph_bank_bit;
      osd_osc_t osc;
      logic vs_s1;
      logic vs_s2;
      logic vs_d;
      logic [7:0] rdata;
      logic [6:0] word;
      logic [6:0] fmt;
      logic blank;
      osd_glyph_t glyph;
      osd_word_t attr;
      logic [8:0] top_lines;
      logic [7:0] left_osc;
      logic [7:0] line_gap_lines;
      logic [6:0] char_lines;
      logic [5:0] char_dots;
      logic [9:0] word_gap_osc;
      logic [2:0] scale;
   } osd_state_t;

   osd_state_t s_r;
   osd_state_t s_nxt;
   // display memory kept apart from the struct so it maps to a RAM
   logic [6:0] vram [OSD_RAM_WORDS];
   logic [6:0] ram_idx;
   logic ram_hit;
   logic ram_we;
   logic win;
   logic p5;
   logic p6;
   logic [5:0] ofs;
   logic unlocked;
   logic vs_rise;
   osd_glyph_t dec_glyph;
   osd_word_t dec_attr;
   logic [8:0] g_top;
   logic [7:0] g_left;
   logic [7:0] g_lgap;
   logic [6:0] g_clines;
   logic [5:0] g_cdots;
   logic [9:0] g_wgap;
   logic [2:0] g_scale;

   // ****************************************
   // address decode
   // ****************************************
   always_comb begin
      win = core_addr <= OSD_WIN_LAST;
      p5 = s_r.page[OSD_PAGE5_BIT];
      // page 5 wins when both bits are set, so no write lands in two places
      p6 = s_r.page[OSD_PAGE6_BIT] & ~s_r.page[OSD_PAGE5_BIT];
      ofs = core_addr[5:0];
      unlocked = ~s_r.osd_master_on;
      ram_hit = win & (p5 | (p6 & ofs <= OSD_P6_RAM_LAST));
      ram_idx = p5 ? {1'b0, ofs} : 7'(OSD_P6_RAM_BASE + 7'(ofs));
      // locked RAM writes fall away here
      ram_we = clk_en & core_wr & ram_hit & unlocked;
   end

   // ****************************************
   // helpers
   // ****************************************
   osd_word_decode u_dec (
      .word(s_r.word),
      .fmt_word(s_r.fmt),
      .osd_master_on(s_r.osd_master_on),
      .glyph_bank_bit(s_r.glyph_bank_bit),
      .no_backdrop_on_spaces(s_r.horizontal_origin[OSD_NOSPACE_BD_BIT]),
      .outline_background_bit(s_r.vertical_origin[OSD_OUTLINE_BIT]),
      .backdrop_enables(s_r.backdrop_setup[7:6]),
      .backdrop_colours(s_r.backdrop_setup[5:0]),
      .glyph(dec_glyph),
      .attr(dec_attr)
   );

   osd_geometry u_geo (
      .top_offset(s_r.vertical_origin[5:0]),
      .left_offset(s_r.horizontal_origin[5:0]),
      .line_gap_value(s_r.line_gap_and_blank[5:0]),
      .line_gap_on(s_r.fmt[OSD_FW_LGAP]),
      .word_gap_value(s_r.word_gap_and_size[5:0]),
      .word_gap_on(s_r.fmt[OSD_FW_WGAP]),
      .global_height_code(s_r.word_gap_and_size[OSD_GS_LSB +: 2]),
      .per_line_height_flag(s_r.fmt[OSD_FW_SIZE]),
      .top_lines(g_top),
      .left_osc(g_left),
      .line_gap_lines(g_lgap),
      .char_lines(g_clines),
      .char_dots(g_cdots),
      .word_gap_osc(g_wgap),
      .scale(g_scale)
   );

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      s_nxt = s_r;
      vs_rise = s_r.vs_s2 & ~s_r.vs_d;
      if (clk_en) begin
         // vsync pin synchroniser; edge taken off the second stage only
         s_nxt.vs_s1 = vsync_in;
         s_nxt.vs_s2 = s_r.vs_s1;
         s_nxt.vs_d = s_r.vs_s2;
         if (core_wr && core_addr == OSD_PAGE_REG_ADDR) begin
            s_nxt.page = core_wdata;
         end
         // master switch answers at any time
         if (core_wr && win && p6 && ofs == OSD_MSW_OFS) begin
            s_nxt.osd_master_on = core_wdata[0];
         end
         if (core_wr && unlocked) begin
            if (core_addr == OSD_BANK_ADDR) begin
               s_nxt.glyph_bank_bit = core_wdata[0];
            end
            if (win && p6) begin
               unique case (ofs)
                  OSD_VORG_OFS: s_nxt.vertical_origin = core_wdata;
                  OSD_HORG_OFS: s_nxt.horizontal_origin = core_wdata;
                  OSD_LGAP_OFS: s_nxt.line_gap_and_blank = core_wdata;
                  OSD_WGAP_OFS: s_nxt.word_gap_and_size = core_wdata;
                  OSD_BKDP_OFS: s_nxt.backdrop_setup = core_wdata;
                  default: ;
               endcase
            end
         end
         // read port; locked locations and master switch read as zero
         s_nxt.rdata = OSD_REG_RESET;
         if (core_rd && core_addr == OSD_PAGE_REG_ADDR) begin
            s_nxt.rdata = s_r.page;
         end else if (core_rd && unlocked) begin
            if (core_addr == OSD_BANK_ADDR) begin
               s_nxt.rdata = {7'd0, s_r.glyph_bank_bit};
            end else if (ram_hit) begin
               s_nxt.rdata = {1'b0, vram[ram_idx]};
            end else if (win && p6) begin
               unique case (ofs)
                  OSD_VORG_OFS: s_nxt.rdata = s_r.vertical_origin;
                  OSD_HORG_OFS: s_nxt.rdata = s_r.horizontal_origin;
                  OSD_LGAP_OFS: s_nxt.rdata = s_r.line_gap_and_blank;
                  OSD_WGAP_OFS: s_nxt.rdata = s_r.word_gap_and_size;
                  OSD_BKDP_OFS: s_nxt.rdata = s_r.backdrop_setup;
                  default: ;
               endcase
            end
         end
         // oscillator gate: start waits for vsync, stop is immediate
         unique case (s_r.osc)
            OSD_OFF: if (s_r.osd_master_on && vs_rise) s_nxt.osc = OSD_RUN;
            OSD_RUN: if (!s_r.osd_master_on) s_nxt.osc = OSD_OFF;
            default: s_nxt.osc = OSD_OFF;
         endcase
         // display-side fetch from the second RAM port
         s_nxt.word = vram[disp_addr];
         s_nxt.fmt = vram[disp_fmt_addr];
         s_nxt.glyph = dec_glyph;
         s_nxt.attr = dec_attr;
         s_nxt.blank = s_r.line_gap_and_blank[OSD_BLANK_BIT] |
                       (s_r.osd_master_on & char_active);
         s_nxt.top_lines = g_top;
         s_nxt.left_osc = g_left;
         s_nxt.line_gap_lines = g_lgap;
         s_nxt.char_lines = g_clines;
         s_nxt.char_dots = g_cdots;
         s_nxt.word_gap_osc = g_wgap;
         s_nxt.scale = g_scale;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
         s_r.osc <= OSD_OFF;
      end else begin
         s_r <= s_nxt;
      end
   end

   // display RAM, no reset: contents undefined until software fills it
   always_ff @(posedge clk) begin
      if (ram_we) begin
         vram[ram_idx] <= core_wdata[6:0];
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign core_rdata = s_r.rdata;
   assign disp_word = s_r.word;
   assign disp_glyph = s_r.glyph;
   assign disp_attr = s_r.attr;
   assign osc_run = s_r.osc == OSD_RUN;
   assign blank_output = s_r.blank;
   assign top_lines = s_r.top_lines;
   assign left_osc = s_r.left_osc;
   assign line_gap_lines = s_r.line_gap_lines;
   assign char_lines = s_r.char_lines;
   assign char_dots = s_r.char_dots;
   assign word_gap_osc = s_r.word_gap_osc;
   assign size_scale = s_r.scale;
endmodule

// File: verif/osd_core_model.sv
`timescale 1ns/100ps
// ****
// processor core and sync source
// ****
module osd_core_model (
   input wire logic clk,
   output logic [7:0] core_addr,
   output logic [7:0] core_wdata,
   output logic core_wr,
   output logic core_rd,
   input wire logic [7:0] core_rdata,
   output logic vsync_in
);
   // idle bus from time zero
   initial begin
      core_addr = 8'h5A;
      core_wdata = 8'hA5;
      core_wr = 1'b0;
      core_rd = 1'b0;
      vsync_in = 1'b0;
   end
   // one write, held across the taking edge; a gap cycle follows
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk);
      core_addr = a;
      core_wdata = v;
      core_wr = 1'b1;
      @(negedge clk);
      core_wr = 1'b0;
      core_addr = ~a;   // released bus must not keep the old value
      core_wdata = ~v;
   endtask
   // read data stands for the cycle after the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk);
      core_addr = a;
      core_rd = 1'b1;
      @(negedge clk);
      v = core_rdata;
      core_rd = 1'b0;
      core_addr = ~a;
   endtask
   // sync pulse kept wide so the two-flop synchroniser sees it
   task automatic vsync(input int hi);
      @(negedge clk);
      vsync_in = 1'b1;
      repeat (hi) @(negedge clk);
      vsync_in = 1'b0;
   endtask
endmodule

// File: verif/osd_ctrl_asserts.sv
`timescale 1ns/100ps
// ****
// port checks of the display control block
// ****
module osd_ctrl_asserts
   import osd_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [7:0] core_addr,
   input wire logic [7:0] core_wdata,
   input wire logic core_wr,
   input wire logic core_rd,
   input wire logic [7:0] core_rdata,
   input wire logic vsync_in,
   input wire logic osc_run,
   input wire logic blank_output,
   input wire logic [8:0] top_lines,
   input wire logic [7:0] left_osc
);
   logic [1:0] page_r;
   logic on_r, bank_r, blank_r, settle_r, p6, free, zero_rd;
   logic [5:0] top_r, left_r;
   // page 5 wins when both page bits are set
   assign p6 = page_r[1] & ~page_r[0];
   assign free = p6 & ~on_r;
   // locked and write-only places read zero
   assign zero_rd = clk_en & core_rd & ((on_r & ((core_addr <= OSD_WIN_LAST)
      | (core_addr == OSD_BANK_ADDR))) | (p6 & (core_addr == 8'h17)));
   // shadow of what the core has managed to store
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         page_r <= 2'b00;
         on_r <= 1'b0;
         bank_r <= 1'b0;
         blank_r <= 1'b0;
         settle_r <= 1'b0;
         top_r <= 6'h00;
         left_r <= 6'h00;
      end else begin
         settle_r <= 1'b1;
         if (clk_en & core_wr) begin
            if (core_addr == OSD_PAGE_REG_ADDR) page_r <= core_wdata[6:5];
            if (p6 & (core_addr == 8'h17)) on_r <= core_wdata[0];
            if (~on_r & (core_addr == OSD_BANK_ADDR)) bank_r <= core_wdata[0];
            if (free & (core_addr == 8'h10)) top_r <= core_wdata[5:0];
            if (free & (core_addr == 8'h11)) left_r <= core_wdata[5:0];
            if (free & (core_addr == 8'h12)) blank_r <= core_wdata[6];
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // sync edge seen while the display stays switched on
   sequence vs_seen;
      $rose(vsync_in) && on_r ##1 on_r [*2];
   endsequence
   sequence osc_up;
      ##[0:2] osc_run;
   endsequence
   a_locked_read_zero: assert property (zero_rd |=> core_rdata == 8'h00)
      else $error("locked or write-only read returned data");
   a_rdata_idle: assert property ((clk_en && !core_rd) |=> core_rdata == 8'h00)
      else $error("read data without a read");
   a_bank_readback: assert property ((clk_en && core_rd && !on_r
      && core_addr == OSD_BANK_ADDR) |=> core_rdata[0] == $past(bank_r))
      else $error("bank bit read back wrong");
   a_osc_start: assert property (vs_seen |=> osc_up)
      else $error("oscillator did not start after sync");
   a_osc_gate: assert property ($rose(osc_run) |-> $past(on_r))
      else $error("oscillator started with display off");
   a_osc_stop: assert property (!on_r |=> !osc_run)
      else $error("oscillator still running with display off");
   a_blank_forced: assert property (blank_r |=> blank_output)
      else $error("screen blank not held");
   a_blank_idle: assert property ((!blank_r && !on_r) |=> !blank_output)
      else $error("blank output active while idle");
   a_top_lines: assert property (settle_r |-> top_lines == {1'b0, $past(top_r), 2'b00})
      else $error("first line start wrong");
   a_left_start: assert property (settle_r |->
      left_osc == 8'(OSD_OSC_PER_DOT * (OSD_HSTART_BASE + $past(left_r))))
      else $error("first character start wrong");
endmodule
bind osd_ctrl osd_ctrl_asserts osd_ctrl_asserts_inst (.clk(clk), .rst(rst), .clk_en(clk_en),
   .core_addr(core_addr), .core_wdata(core_wdata), .core_wr(core_wr), .core_rd(core_rd),
   .core_rdata(core_rdata), .vsync_in(vsync_in), .osc_run(osc_run),
   .blank_output(blank_output), .top_lines(top_lines), .left_osc(left_osc));

// File: verif/osd_control_registers_bench.sv
`timescale 1ns/100ps
// ****
// bench for the display control block
// ****
module osd_control_registers_bench;
   import osd_pkg::*;
   logic clk, rst, char_active, core_wr, core_rd, vsync_in, osc_run, blank_output;
   logic [7:0] core_addr, core_wdata, core_rdata, d, left_osc, line_gap_lines;
   logic [6:0] disp_addr, disp_fmt_addr, disp_word, char_lines;
   logic [8:0] top_lines;
   logic [9:0] word_gap_osc;
   logic clk_en;
   logic [5:0] char_dots;
   logic [2:0] size_scale;
   osd_glyph_t disp_glyph;
   osd_word_t disp_attr;
   int mismatches, total_checks, bank;
   int ram[80];
   int regs[5];
   int sc[8] = '{1, 2, 1, 3, 2, 3, 2, 4};
   logic [7:0] offs[5] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14};
   logic [7:0] msk[5] = '{8'h7F, 8'h7F, 8'h7F, 8'hFF, 8'hFF};
   osd_ctrl osd_ctrl_inst (.clk(clk), .rst(rst), .clk_en(clk_en), .core_addr(core_addr),
      .core_wdata(core_wdata), .core_wr(core_wr), .core_rd(core_rd), .core_rdata(core_rdata),
      .vsync_in(vsync_in), .disp_addr(disp_addr), .disp_fmt_addr(disp_fmt_addr),
      .char_active(char_active), .disp_word(disp_word), .disp_glyph(disp_glyph),
      .disp_attr(disp_attr), .osc_run(osc_run), .blank_output(blank_output),
      .top_lines(top_lines), .left_osc(left_osc), .line_gap_lines(line_gap_lines),
      .char_lines(char_lines), .char_dots(char_dots), .word_gap_osc(word_gap_osc),
      .size_scale(size_scale));
   osd_core_model osd_core_model_inst (.clk(clk), .core_addr(core_addr),
      .core_wdata(core_wdata), .core_wr(core_wr), .core_rd(core_rd),
      .core_rdata(core_rdata), .vsync_in(vsync_in));
   always #5 clk = ~clk;
   // compare helpers, one per kind of result
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: output %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      osd_core_model_inst.wr(a, v);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      osd_core_model_inst.rd(a, d);
      chk_reg(d, exp);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // registers, then the lock while the display is on
   task automatic t_regs();
      wr(OSD_PAGE_REG_ADDR, 8'h40);
      for (int i = 0; i < 5; i++) begin
         regs[i] = ($urandom_range(255) | 1) & msk[i];
         wr(offs[i], 8'(regs[i]));
      end
      bank = $urandom_range(1);
      wr(OSD_BANK_ADDR, 8'(bank));
      foreach (regs[i]) rdc(offs[i], 8'(regs[i]));
      rdc(OSD_BANK_ADDR, 8'(bank));
      rdc(8'h17, 8'h00);
      rdc(8'h15, 8'h00);
      wr(8'h17, 8'h01);
      foreach (regs[i]) wr(offs[i], ~8'(regs[i]));
      wr(OSD_BANK_ADDR, 8'(1 - bank));
      foreach (regs[i]) rdc(offs[i], 8'h00);
      wr(8'h17, 8'h00);
      foreach (regs[i]) rdc(offs[i], 8'(regs[i]));
      rdc(OSD_BANK_ADDR, 8'(bank));
      // a frozen clock enable must swallow the write
      clk_en = 1'b0;
      wr(offs[0], ~8'(regs[0]));
      clk_en = 1'b1;
      rdc(offs[0], 8'(regs[0]));
      $display("register test done");
   endtask
   // all 80 words through both pages and the display port
   task automatic t_ram();
      for (int i = 0; i < OSD_RAM_WORDS; i++) begin
         if (i % 64 == 0) wr(OSD_PAGE_REG_ADDR, (i == 0) ? 8'h20 : 8'h40);
         ram[i] = $urandom_range(127);
         wr(8'(i % 64), 8'(ram[i]) | 8'h80);
         rdc(8'(i % 64), 8'(ram[i]));
      end
      for (int i = 0; i < OSD_RAM_WORDS; i++) begin
         disp_addr = 7'(i);
         @(negedge clk);
         chk_out(16'(disp_word), 16'(ram[i]));
         @(negedge clk);
         chk_out(16'(disp_glyph), 16'({ram[i][5:0], bank[0], ~ram[i][6]}));
      end
      wr(8'h17, 8'h01);
      wr(8'h05, 8'(~ram[69]));
      wr(8'h17, 8'h00);
      rdc(8'h05, 8'(ram[69]));
      $display("display memory test done");
   endtask
   // every size code with random gap settings
   task automatic t_geo();
      logic [5:0] wg, lg;
      logic lon;
      for (int c = 0; c < 8; c++) begin
         wg = 6'($urandom);
         lg = 6'($urandom) | 6'h01;
         lon = 1'($urandom);
         wr(8'h12, {2'b00, lg});
         wr(8'h13, {2'(c >> 1), wg});
         ram[64] = {5'b1_0000, lon, 1'(c)};
         wr(8'h00, 8'(ram[64]));
         disp_fmt_addr = 7'd64;
         repeat (4) @(negedge clk);
         chk_out(16'(char_lines), 16'(18 * sc[c]));
         chk_out(16'(char_dots), 16'(6 * sc[c]));
         chk_out(16'(size_scale), 16'(sc[c]));
         chk_out(16'(line_gap_lines), lon ? 16'(4 * lg) : 16'h0000);
         chk_out(16'(word_gap_osc), c[0] ? 16'(2 * (1 + wg) * sc[c]) : 16'h0000);
      end
      $display("geometry test done");
   endtask
   // backdrop choice, blanking and oscillator with the display on
   task automatic t_attr();
      logic [7:0] bd, fw, w;
      logic nbs, fr;
      for (int k = 0; k < 8; k++) begin
         bd = 8'($urandom);
         fw = {2'b01, 6'($urandom)};
         w = 8'($urandom_range(127));
         nbs = 1'($urandom);
         fr = 1'($urandom);
         wr(8'h17, 8'h00);
         wr(8'h14, bd);
         wr(8'h10, {1'b0, fr, 6'h21});
         wr(8'h11, {1'b0, nbs, 6'h05});
         wr(8'h12, {1'b0, k[0], 6'h01});
         wr(8'h01, fw);
         wr(8'h02, w);
         disp_fmt_addr = 7'd65;
         disp_addr = 7'd66;
         char_active = 1'($urandom);
         wr(8'h17, 8'h01);
         osd_core_model_inst.vsync(6);
         repeat (2) @(negedge clk);
         chk_out(16'(disp_attr.draw_backdrop), 16'(bd[6 + fw[3]] & ~(nbs & w[6])));
         chk_out(16'(disp_attr.backdrop_colour), 16'(fw[3] ? bd[5:3] : bd[2:0]));
         chk_out(16'(disp_attr.word_visible), 16'(fw[2]));
         chk_out(16'(disp_attr.outline), 16'(fr));
         chk_out(16'(disp_attr.colour), 16'(fw[6:4]));
         chk_out(16'(blank_output), 16'(k[0] | char_active));
         chk_out(16'(osc_run), 16'h0001);
      end
      $display("backdrop test done");
   endtask
   // main sequence, reset held six cycles
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      char_active = 1'b0;
      clk_en = 1'b1;
      disp_addr = 7'd0;
      disp_fmt_addr = 7'd0;
      mismatches = 0;
      total_checks = 0;
      void'($urandom(32'h83d2_5e1f));
      repeat (6) @(negedge clk);
      rst = 1'b0;
      t_regs();
      t_ram();
      t_geo();
      t_attr();
      conclude();
   end
   // watchdog at 20000 cycles, well past the under 1000 cycles the tests need
   initial begin
      #200_000;
      mismatches++;
      conclude();
   end
endmodule
